/* File: gtlr_checker.sv */
// Port-level assertions for the talker/listener top module
`timescale 1ns/100ps
module gtlr_checker import gtlr_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic addr_set,
  input wire logic [4:0] addr_val,
  input wire logic [4:0] addr,
  input wire logic addr_reject,
  input wire gtlr_bus_t bus_in,
  input wire logic ifc,
  input wire logic ren,
  input wire logic local_key,
  input wire logic remote_led,
  input wire logic keys_locked,
  input wire logic lockout,
  input wire logic talker,
  input wire logic listener,
  input wire logic spoll,
  input wire logic [7:0] stb,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic cal_done,
  input wire logic dev_clear,
  input wire gtlr_set_t set_evt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence cmd_s(logic [7:0] c);
    bus_in.valid && bus_in.atn && bus_in.data == c;
  endsequence
  sequence ren_up_s;
    !ren && !remote_led ##1 ren;
  endsequence
  // Third cycle of poll mode: the status byte has had time to land
  sequence poll_s;
    spoll ##1 spoll ##1 spoll;
  endsequence
  addr_range_a:
    assert property (addr <= ADDR_MAX) else $error("address out of range");
  addr_refuse_a:
    assert property (addr_set && addr_val > ADDR_MAX |=>
      addr_reject && addr == $past(addr)) else $error("bad address taken");
  addr_take_a:
    assert property (addr_set && addr_val <= ADDR_MAX |=>
      addr == $past(addr_val) && !addr_reject) else $error("address lost");
  listen_addr_a:
    assert property (cmd_s(LAD_BASE | {3'b000, addr}) |=> listener && !talker)
      else $error("listen address ignored");
  talk_addr_a:
    assert property (cmd_s(TAD_BASE | {3'b000, addr}) |=> talker && !listener)
      else $error("talk address ignored");
  ifc_clear_a:
    assert property (ifc |=> !talker && !listener && !spoll)
      else $error("interface clear ignored");
  dcl_pulse_a:
    assert property (cmd_s(CMD_DCL) |=> dev_clear) else $error("no clear");
  remote_on_a:
    assert property (ren_up_s |=> remote_led && keys_locked)
      else $error("remote not entered");
  local_key_a:
    assert property (remote_led && !lockout && ren && local_key |=>
      !remote_led) else $error("local key ignored");
  lockout_key_a:
    assert property (remote_led && lockout && ren && local_key |=>
      remote_led) else $error("local key obeyed under lockout");
  llo_set_a:
    assert property (cmd_s(CMD_LLO) ##0 ren |=> lockout)
      else $error("no llo");
  poll_byte_a:
    assert property (poll_s ##0 talker |-> tx_valid &&
      tx_byte == $past(stb)) else $error("poll byte wrong");
  cal_after_a:
    assert property (cal_done |=> set_evt.restore && set_evt.meas_stop &&
      set_evt.data_void) else $error("calibration aftermath missing");
  power_on_a:
    assert property ($fell(rst) |=> set_evt.power_on) else $error("no power");
endmodule // gtlr_checker
bind gtlr_top gtlr_checker u_chk (.*);

/* File: gtlr_ctl_model.sv */
// Behavioural bus controller that addresses, writes and reads the device
`timescale 1ns/100ps
module gtlr_ctl_model import gtlr_pkg::*; (
  input wire logic clk,
  input wire logic bus_rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output gtlr_bus_t bus_in,
  output logic ifc,
  output logic ren,
  output logic tx_ack,
  output logic tmo
);
  int slow = 0;
  initial
  begin
    bus_in = '{valid: 1'b0, atn: 1'b0, data: 8'hA5};
    {ifc, ren, tx_ack, tmo} = 4'h0;
  end
  // Data bytes wait for room; interface commands go regardless
  task automatic put(input logic atn, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    while (!atn && !bus_rx_ready && n < 400)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 400) tmo <= 1'b1;
    bus_in <= '{valid: 1'b1, atn: atn, data: d};
    @(posedge clk);
    // A released line shows the inverse, never the stale byte
    bus_in <= '{valid: 1'b0, atn: 1'b0, data: ~d};
  endtask
  task automatic get(output logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    while (!tx_valid && n < 400)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 400) tmo <= 1'b1;
    b = tx_byte;
    repeat (slow) @(posedge clk);
    tx_ack <= 1'b1;
    @(posedge clk);
    tx_ack <= 1'b0;
  endtask
  task automatic lines(input logic i, input logic r);
    @(posedge clk);
    ifc <= i;
    ren <= r;
  endtask
endmodule // gtlr_ctl_model

/* File: gtlr_fifo.sv */
// Receive FIFO with registered read data and registered ready
`timescale 1ns/100ps
module gtlr_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic ov_reg, ov_next, rdy_reg, rdy_next;
  logic [W-1:0] od_reg, od_next;
  logic push, pop;

  // Output stage holds one word, so capacity is D plus one
  always_comb
  begin
    push = in_valid && rdy_reg;
    pop = (cnt_reg != '0) && (!ov_reg || out_ready);
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    ov_next = ov_reg;
    od_next = od_reg;
    if (push)
      wr_next = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
    if (pop)
    begin
      rd_next = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;
      od_next = mem[rd_reg];
      ov_next = 1'b1;
    end
    else if (out_ready)
      ov_next = 1'b0;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush)
    begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
      ov_next = 1'b0;
    end
    rdy_next = (cnt_next != (AW+1)'(D));
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ov_reg <= 1'b0;
      od_reg <= '0;
      rdy_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      ov_reg <= ov_next;
      od_reg <= od_next;
      rdy_reg <= rdy_next;
    end
  end

  assign in_ready = rdy_reg;
  assign out_valid = ov_reg;
  assign out_data = od_reg;
endmodule // gtlr_fifo

/* File: gtlr_pkg.sv */
// Shared constants and carrier types for the bus talker/listener block
package gtlr_pkg;
  // Addressing
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  localparam logic [4:0] ADDR_RST = 5'h01;
  // Interface commands seen with attention asserted
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] LAD_BASE = 8'h20;
  localparam logic [7:0] CMD_UNL = 8'h3F;
  localparam logic [7:0] TAD_BASE = 8'h40;
  localparam logic [7:0] CMD_UNT = 8'h5F;
  localparam logic [7:0] GRP_MASK = 8'hE0;
  // Characters of program and response messages
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_LPAR = 8'h28;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_ONE = 8'h31;
  // Common command headers, right aligned, without the star
  localparam logic [31:0] HDR_TST = 32'h5453543F;
  localparam logic [31:0] HDR_RST = 32'h00525354;
  localparam logic [31:0] HDR_DMC = 32'h00444D43;
  localparam logic [31:0] HDR_EMC = 32'h00454D43;
  localparam logic [31:0] HDR_EMCQ = 32'h454D433F;
  localparam logic [31:0] HDR_GMCQ = 32'h474D433F;
  localparam logic [31:0] HDR_LMCQ = 32'h4C4D433F;
  localparam logic [31:0] HDR_PMC = 32'h00504D43;
  localparam logic [31:0] HDR_RMC = 32'h00524D43;
  localparam logic [31:0] HDR_DDT = 32'h00444454;
  localparam logic [31:0] HDR_DDTQ = 32'h4444543F;
  localparam logic [31:0] HDR_PUD = 32'h00505544;
  localparam logic [31:0] HDR_PUDQ = 32'h5055443F;
  localparam logic [31:0] HDR_RDT = 32'h00524454;
  localparam logic [31:0] HDR_RDTQ = 32'h5244543F;
  localparam logic [31:0] HDR_LRNQ = 32'h4C524E3F;
  // Receive buffer and path FIFO
  localparam int unsigned RX_BUF_BYTES = 65536;
  localparam int unsigned RX_FIFO_DEPTH = 16;

  typedef struct packed {
    logic valid;
    logic atn;
    logic [7:0] data;
  } gtlr_bus_t;

  typedef struct packed {
    logic power_on;
    logic factory;
    logic restore;
    logic meas_stop;
    logic data_void;
  } gtlr_set_t;

  typedef struct packed {
    logic expr;
    logic unsup;
    logic block;
    logic overflow;
  } gtlr_err_t;
endpackage

/* File: gtlr_top.sv */
// Instrument-side talker/listener, message parser and remote/local control
`timescale 1ns/100ps
module gtlr_top import gtlr_pkg::*; #(
  parameter int unsigned RX_BYTES = RX_BUF_BYTES,
  parameter int unsigned FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic addr_set,
  input wire logic [4:0] addr_val,
  output logic [4:0] addr,
  output logic addr_reject,
  input wire gtlr_bus_t bus_in,
  output logic bus_rx_ready,
  input wire logic ifc,
  input wire logic ren,
  input wire logic local_key,
  output logic remote_led,
  output logic keys_locked,
  output logic lockout,
  output logic talker,
  output logic listener,
  output logic spoll,
  input wire logic [7:0] stb,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ack,
  output logic app_valid,
  output logic [7:0] app_byte,
  input wire logic app_ready,
  output logic app_exec,
  output logic common_valid,
  output logic [31:0] common_hdr,
  input wire logic app_done,
  input wire logic resp_valid,
  input wire logic [7:0] resp_byte,
  output logic resp_ready,
  input wire logic cal_done,
  output logic dev_clear,
  output gtlr_set_t set_evt,
  output gtlr_err_t err
);
  typedef enum logic [2:0] {
    S_IDLE, S_APP, S_COM, S_CDEC, S_WAIT, S_TST1, S_TST2
  } gtlr_state_t;

  logic [4:0] addr_reg, addr_next;
  logic rej_reg, rej_next;
  logic tlk_reg, tlk_next, lsn_reg, lsn_next;
  logic sp_reg, sp_next, llo_reg, llo_next;
  logic rem_reg, rem_next, ren_reg;
  logic clr_reg, clr_next;
  logic pon_reg;
  gtlr_set_t set_reg, set_next;
  gtlr_err_t err_reg, err_next;
  logic [16:0] len_reg, len_next;
  logic drop_reg, drop_next;
  gtlr_state_t st_reg, st_next;
  logic [31:0] hdr_reg, hdr_next;
  logic av_reg, av_next, ex_reg, ex_next;
  logic [7:0] ab_reg, ab_next;
  logic cv_reg, cv_next;
  logic q_v_reg, q_v_next;
  logic [7:0] q_b_reg, q_b_next;
  logic first_reg, first_next;
  logic rr_reg, rr_next;
  logic tv_reg, tv_next;
  logic [7:0] tb_reg, tb_next;
  logic f_valid, f_ready, f_in_valid, f_in_ready, f_flush;
  logic [7:0] f_data;
  logic cmd, is_tad, my_lad, my_tad, data_in, take, term;
  logic dclr;
  logic ovf_next, fac_next;

  function automatic logic unsup_hdr(input logic [31:0] h);
    unique case (h)
      HDR_DMC, HDR_EMC, HDR_EMCQ, HDR_GMCQ, HDR_LMCQ, HDR_PMC, HDR_RMC,
      HDR_DDT, HDR_DDTQ, HDR_PUD, HDR_PUDQ, HDR_RDT, HDR_RDTQ,
      HDR_LRNQ: unsup_hdr = 1'b1;
      default: unsup_hdr = 1'b0;
    endcase
  endfunction

  // Bus addressing, interface commands and remote/local control
  always_comb
  begin
    cmd = bus_in.valid && bus_in.atn;
    is_tad = (bus_in.data & GRP_MASK) == TAD_BASE;
    my_lad = cmd && bus_in.data == (LAD_BASE | {3'b000, addr_reg});
    my_tad = cmd && bus_in.data == (TAD_BASE | {3'b000, addr_reg});
    addr_next = addr_reg;
    rej_next = 1'b0;
    if (addr_set)
    begin
      if (addr_val <= ADDR_MAX)
        addr_next = addr_val;
      else
        rej_next = 1'b1;
    end
    tlk_next = tlk_reg;
    lsn_next = lsn_reg;
    sp_next = sp_reg;
    llo_next = llo_reg;
    rem_next = rem_reg;
    dclr = 1'b0;
    // Addressed operation only: no path makes talker or listener self-set
    if (my_lad)
    begin
      lsn_next = 1'b1;
      if (tlk_reg && !my_tad)
        tlk_next = 1'b0;
    end
    else if (cmd && bus_in.data == CMD_UNL)
      lsn_next = 1'b0;
    if (my_tad)
    begin
      tlk_next = 1'b1;
      lsn_next = 1'b0;
    end
    else if (cmd && (bus_in.data == CMD_UNT || is_tad))
      tlk_next = 1'b0;
    if (cmd && bus_in.data == CMD_SPE)
      sp_next = 1'b1;
    if (cmd && bus_in.data == CMD_SPD)
      sp_next = 1'b0;
    if (cmd && bus_in.data == CMD_LLO)
      llo_next = 1'b1;
    if (cmd && (bus_in.data == CMD_DCL ||
        (bus_in.data == CMD_SDC && lsn_reg)))
      dclr = 1'b1;
    if (ren && !ren_reg && !rem_reg)
      rem_next = 1'b1;
    if (rem_reg && local_key && !llo_reg)
      rem_next = 1'b0;
    if (cmd && bus_in.data == CMD_GTL && lsn_reg)
      rem_next = 1'b0;
    if (!ren)
    begin
      rem_next = 1'b0;
      llo_next = 1'b0;
    end
    if (ifc)
    begin
      tlk_next = 1'b0;
      lsn_next = 1'b0;
      sp_next = 1'b0;
    end
    clr_next = dclr;
  end

  // Incoming data: message length guard in front of the FIFO
  always_comb
  begin
    data_in = bus_in.valid && !bus_in.atn && lsn_reg;
    len_next = len_reg;
    drop_next = drop_reg;
    f_in_valid = 1'b0;
    ovf_next = 1'b0;
    if (data_in && f_in_ready)
    begin
      if (bus_in.data == CH_LF)
      begin
        len_next = '0;
        drop_next = 1'b0;
        f_in_valid = !drop_reg;
      end
      else if (drop_reg)
        f_in_valid = 1'b0;
      else if (len_reg == 17'(RX_BYTES))
      begin
        drop_next = 1'b1;
        ovf_next = 1'b1;
      end
      else
      begin
        len_next = len_reg + 17'h00001;
        f_in_valid = 1'b1;
      end
    end
    if (dclr)
    begin
      len_next = '0;
      drop_next = 1'b0;
    end
  end

  assign f_flush = dclr;

  gtlr_fifo #(.W(8), .D(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .flush(f_flush),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(bus_in.data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Parser: one command at a time, answers only after parse ends
  always_comb
  begin
    term = f_data == CH_LF || f_data == CH_SEMI;
    st_next = st_reg;
    hdr_next = hdr_reg;
    av_next = av_reg && !app_ready;
    ab_next = ab_reg;
    ex_next = 1'b0;
    cv_next = 1'b0;
    q_v_next = q_v_reg && !(tx_ack && tlk_reg && !sp_reg);
    q_b_next = q_b_reg;
    first_next = first_reg;
    err_next.expr = 1'b0;
    err_next.unsup = 1'b0;
    err_next.block = 1'b0;
    err_next.overflow = ovf_next;
    fac_next = 1'b0;
    f_ready = 1'b0;
    unique case (st_reg)
      S_IDLE, S_APP:
      begin
        f_ready = !av_reg || app_ready;
        take = f_valid && f_ready;
        if (take && st_reg == S_IDLE && f_data == CH_STAR)
        begin
          st_next = S_COM;
          hdr_next = '0;
        end
        else if (take && st_reg == S_IDLE &&
                 (term || f_data == CH_SP || f_data == CH_CR))
          st_next = S_IDLE;
        else if (take)
        begin
          av_next = 1'b1;
          ab_next = f_data;
          st_next = S_APP;
          if (f_data == CH_LPAR)
            err_next.expr = 1'b1;
          if (term)
          begin
            ex_next = 1'b1;
            first_next = 1'b1;
            st_next = S_WAIT;
          end
        end
      end
      S_COM:
      begin
        f_ready = 1'b1;
        if (f_valid && term)
          st_next = S_CDEC;
        else if (f_valid)
          hdr_next = {hdr_reg[23:0], f_data};
      end
      S_CDEC:
      begin
        if (hdr_reg == HDR_TST)
          st_next = S_TST1;
        else if (unsup_hdr(hdr_reg))
        begin
          err_next.unsup = 1'b1;
          st_next = S_IDLE;
        end
        else if (hdr_reg == HDR_RST)
        begin
          fac_next = 1'b1;
          st_next = S_IDLE;
        end
        else
        begin
          cv_next = 1'b1;
          first_next = 1'b1;
          st_next = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (resp_valid && rr_reg)
        begin
          first_next = 1'b0;
          if (first_reg && resp_byte == CH_HASH)
            err_next.block = 1'b1;
          else
          begin
            q_v_next = 1'b1;
            q_b_next = resp_byte;
          end
        end
        if (app_done)
          st_next = S_IDLE;
      end
      S_TST1:
      begin
        if (!q_v_next)
        begin
          q_v_next = 1'b1;
          q_b_next = CH_ONE;
          st_next = S_TST2;
        end
      end
      S_TST2:
      begin
        if (!q_v_next)
        begin
          q_v_next = 1'b1;
          q_b_next = CH_LF;
          st_next = S_IDLE;
        end
      end
    endcase
    take = f_valid && f_ready;
    if (dclr)
    begin
      st_next = S_IDLE;
      av_next = 1'b0;
      q_v_next = 1'b0;
    end
    if (ifc)
      q_v_next = 1'b0;
    rr_next = st_next == S_WAIT && !q_v_next && !dclr;
    // Poll mode sends the status byte instead of queued output
    tv_next = tlk_next && (sp_next || q_v_next);
    tb_next = sp_next ? stb : q_b_next;
  end

  // Settings events; settings themselves are kept untouched on mode change
  always_comb
  begin
    set_next.power_on = !pon_reg;
    set_next.factory = fac_next;
    set_next.restore = cal_done;
    set_next.meas_stop = cal_done;
    set_next.data_void = cal_done;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_reg <= ADDR_RST;
      rej_reg <= 1'b0;
      tlk_reg <= 1'b0;
      lsn_reg <= 1'b0;
      sp_reg <= 1'b0;
      llo_reg <= 1'b0;
      rem_reg <= 1'b0;
      ren_reg <= 1'b0;
      clr_reg <= 1'b0;
      pon_reg <= 1'b0;
      set_reg <= '0;
      err_reg <= '0;
      len_reg <= '0;
      drop_reg <= 1'b0;
      st_reg <= S_IDLE;
      hdr_reg <= '0;
      av_reg <= 1'b0;
      ab_reg <= '0;
      ex_reg <= 1'b0;
      cv_reg <= 1'b0;
      q_v_reg <= 1'b0;
      q_b_reg <= '0;
      first_reg <= 1'b0;
      rr_reg <= 1'b0;
      tv_reg <= 1'b0;
      tb_reg <= '0;
    end
    else
    begin
      addr_reg <= addr_next;
      rej_reg <= rej_next;
      tlk_reg <= tlk_next;
      lsn_reg <= lsn_next;
      sp_reg <= sp_next;
      llo_reg <= llo_next;
      rem_reg <= rem_next;
      ren_reg <= ren;
      clr_reg <= clr_next;
      pon_reg <= 1'b1;
      set_reg <= set_next;
      err_reg <= err_next;
      len_reg <= len_next;
      drop_reg <= drop_next;
      st_reg <= st_next;
      hdr_reg <= hdr_next;
      av_reg <= av_next;
      ab_reg <= ab_next;
      ex_reg <= ex_next;
      cv_reg <= cv_next;
      q_v_reg <= q_v_next;
      q_b_reg <= q_b_next;
      first_reg <= first_next;
      rr_reg <= rr_next;
      tv_reg <= tv_next;
      tb_reg <= tb_next;
    end
  end

  assign addr = addr_reg;
  assign addr_reject = rej_reg;
  assign bus_rx_ready = f_in_ready;
  assign remote_led = rem_reg;
  assign keys_locked = rem_reg;
  assign lockout = llo_reg;
  assign talker = tlk_reg;
  assign listener = lsn_reg;
  assign spoll = sp_reg;
  assign tx_valid = tv_reg;
  assign tx_byte = tb_reg;
  assign app_valid = av_reg;
  assign app_byte = ab_reg;
  assign app_exec = ex_reg;
  assign common_valid = cv_reg;
  assign common_hdr = hdr_reg;
  assign resp_ready = rr_reg;
  assign dev_clear = clr_reg;
  assign set_evt = set_reg;
  assign err = err_reg;
endmodule // gtlr_top

/* File: tb.sv */
// Self-checking bench for the talker/listener with a controller model
`timescale 1ns/100ps
module tb import gtlr_pkg::*;;
  logic clk, rst, addr_set, addr_reject, bus_rx_ready, ifc, ren, local_key;
  logic [4:0] addr_val, addr, v;
  logic remote_led, keys_locked, lockout, talker, listener, spoll, tmo;
  logic [7:0] stb, tx_byte, app_byte, resp_byte, b;
  logic tx_valid, tx_ack, app_valid, app_ready, app_exec, common_valid;
  logic app_done, resp_valid, resp_ready, cal_done, dev_clear;
  logic [31:0] common_hdr, rng, com_hdr;
  gtlr_bus_t bus_in;
  gtlr_set_t set_evt;
  gtlr_err_t err;
  int err_count = 0, total_checks = 0, exp_addr = 1;
  int n_exec = 0, n_dcl = 0, n_pwr = 0, n_fac = 0, n_cal = 0;
  int n_uns = 0, n_expr = 0, n_blk = 0, n_ovf = 0, n_com = 0;
  logic [7:0] app_q [$];
  logic [4:0] avals [3] = '{5'h00, 5'h1F, 5'h1E};
  string hdr [15] = '{"*DMC", "*EMC", "*EMC?", "*GMC?", "*LMC?", "*PMC",
    "*RMC", "*DDT", "*DDT?", "*PUD", "*PUD?", "*RDT", "*RDT?", "*LRN?",
    "*RST"};
  string cmd2 = "X(2)YYYYYYYYYYYYYYYYYYYYYYYY\n";
  string exp_s;
  gtlr_top #(.RX_BYTES(32), .FIFO_DEPTH(16)) dut (.*);
  gtlr_ctl_model ctl (.clk(clk), .bus_rx_ready(bus_rx_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .bus_in(bus_in), .ifc(ifc),
    .ren(ren), .tx_ack(tx_ack), .tmo(tmo));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo_chk(input logic ok);
    if (!ok)
    begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic wait_ge(ref int c, input int t);
    for (int n = 0; n < 600 && c < t; n++) @(posedge clk);
    tmo_chk(c >= t);
  endtask
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) ctl.put(1'b0, s[i]);
  endtask
  task automatic ta(input logic [7:0] base);
    ctl.put(1'b1, base | 8'(exp_addr));
  endtask
  task automatic pulse_done;
    @(posedge clk);
    app_done <= 1'b1;
    @(posedge clk);
    app_done <= 1'b0;
  endtask
  task automatic key;
    @(posedge clk);
    local_key <= 1'b1;
    @(posedge clk);
    local_key <= 1'b0;
    @(negedge clk);
  endtask
  task automatic respond(input logic [7:0] d);
    int n;
    @(posedge clk);
    resp_valid <= 1'b1;
    resp_byte <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!resp_ready && n < 400);
    resp_valid <= 1'b0;
    resp_byte <= ~d;
    tmo_chk(n < 400);
  endtask
  // Random stalls on the application side keep the FIFO under pressure
  always @(posedge clk)
  begin
    rng <= xs(rng);
    app_ready <= rng[0] | rng[1];
    if (app_valid && app_ready) app_q.push_back(app_byte);
    n_exec += app_exec;
    n_dcl += dev_clear;
    n_pwr += set_evt.power_on;
    n_fac += set_evt.factory;
    n_cal += set_evt.restore & set_evt.meas_stop & set_evt.data_void;
    n_uns += err.unsup;
    n_expr += err.expr;
    n_blk += err.block;
    n_ovf += err.overflow;
    n_com += common_valid;
    if (common_valid) com_hdr = common_hdr;
    if (tmo) tmo_chk(1'b0);
  end
  initial
  begin
    rng = 32'h00005E1A;
    rst = 1'b1;
    {addr_set, local_key, app_done, resp_valid, cal_done, app_ready} = '0;
    addr_val = 5'h00;
    stb = 8'hC3;
    resp_byte = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("addr", 1, addr);
    chk("power_on", 1, n_pwr);
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk);
      v = i < 3 ? avals[i] : i < 5 ? rng[4:0] : 5'h07;
      @(posedge clk);
      addr_set <= 1'b1;
      addr_val <= v;
      @(posedge clk);
      addr_set <= 1'b0;
      addr_val <= ~v;
      @(negedge clk);
      if (v <= 30) exp_addr = v;
      chk("addr_reject", v > 30, addr_reject);
      chk("addr", exp_addr, addr);
    end
    $display("test address done");
    ta(LAD_BASE);
    @(negedge clk);
    chk("listener", 1, listener);
    chk("talker", 0, talker);
    send("*TST?");
    ta(TAD_BASE);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("talker", 1, talker);
    chk("listener", 0, listener);
    chk("tx_valid", 0, tx_valid);
    ta(LAD_BASE);
    send("\n");
    ta(TAD_BASE);
    ctl.get(b);
    chk("tst byte", CH_ONE, b);
    ctl.slow = 3;
    ctl.get(b);
    chk("tst end", CH_LF, b);
    $display("test self-test query done");
    ta(LAD_BASE);
    foreach (hdr[i])
    begin
      send({hdr[i], "\n"});
      if (i < 14) wait_ge(n_uns, i + 1);
    end
    wait_ge(n_fac, 1);
    chk("exec", 0, n_exec);
    send("*CLS\n");
    wait_ge(n_com, 1);
    chk("common hdr", 32'h00434C53, com_hdr);
    pulse_done();
    $display("test common commands done");
    send("VOLT 1\n");
    wait_ge(n_exec, 1);
    fork
      send(cmd2);
      begin
        for (int k = 0; k < 400 && bus_rx_ready; k++) @(posedge clk);
        chk("rx_ready", 0, bus_rx_ready);
        chk("app count", 7, app_q.size());
        pulse_done();
      end
    join
    wait_ge(n_exec, 2);
    for (int k = 0; k < 40 && app_valid; k++) @(posedge clk);
    chk("expr", 1, n_expr);
    exp_s = {"VOLT 1\n", cmd2};
    chk("app total", exp_s.len(), app_q.size());
    foreach (app_q[k]) chk("app byte", exp_s[k], app_q[k]);
    pulse_done();
    send("MEAS?\n");
    wait_ge(n_exec, 3);
    respond(CH_HASH);
    respond(8'h35);
    pulse_done();
    ta(TAD_BASE);
    ctl.get(b);
    chk("answer", 8'h35, b);
    chk("block", 1, n_blk);
    ta(LAD_BASE);
    for (int k = 0; k < 40; k++) ctl.put(1'b0, 8'h5A);
    ctl.put(1'b0, CH_LF);
    wait_ge(n_ovf, 1);
    repeat (20) @(posedge clk);
    if (n_exec > 3) pulse_done();
    $display("test program messages done");
    ctl.lines(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("remote", 1, remote_led);
    chk("keys", 1, keys_locked);
    key();
    chk("remote", 0, remote_led);
    ctl.lines(1'b0, 1'b0);
    ctl.lines(1'b0, 1'b1);
    ctl.put(1'b1, CMD_LLO);
    key();
    chk("lockout", 1, lockout);
    chk("remote", 1, remote_led);
    ctl.lines(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("lockout", 0, lockout);
    $display("test remote local done");
    ta(TAD_BASE);
    ctl.put(1'b1, CMD_SPE);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("spoll", 1, spoll);
    chk("poll valid", 1, tx_valid);
    chk("poll byte", stb, tx_byte);
    ctl.put(1'b1, CMD_SPD);
    @(negedge clk);
    chk("spoll", 0, spoll);
    ta(LAD_BASE);
    ctl.lines(1'b1, 1'b0);
    ctl.lines(1'b0, 1'b0);
    @(negedge clk);
    chk("listener", 0, listener);
    ctl.put(1'b1, CMD_DCL);
    wait_ge(n_dcl, 1);
    @(posedge clk);
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    wait_ge(n_cal, 1);
    $display("test clears and calibration done");
    print_verdict();
  end
endmodule // tb
